// >>> lcd_scan_defs.svh
// constants of the lcd key scan control
`ifndef LCD_SCAN_DEFS_SVH
`define LCD_SCAN_DEFS_SVH

// ----------
// register addresses
// ----------
`define ADDR_LEVEL_LOW 16'hff0e
`define ADDR_LEVEL_HIGH 16'hff0f
`define ADDR_PORT4_DIR 16'hff24
`define ADDR_PULL_UP 16'hff34
`define ADDR_KEY_RETURN 16'hff6e
`define ADDR_CLOCK_SEL 16'hffb2
`define ADDR_DISPLAY_MODE 16'hffb0
`define ADDR_RESISTOR_MODE 16'hffb1

// ----------
// reset values and writable masks
// ----------
`define RST_ZERO 8'h00
`define RST_PORT4_DIR 8'hff
`define MASK_DISPLAY_MODE 8'hd7
`define MASK_RESISTOR_MODE 8'h31
`define MASK_CLOCK_SEL 8'h77
`define MASK_ALL 8'hff

// ----------
// field positions
// ----------
`define DM_SLICE_MSB 2
`define DM_SLICE_LSB 0
`define DM_BOOST_BIT 4
`define DM_DRIVE_BIT 6
`define DM_ON_BIT 7
`define RM_KEY_SCAN_BIT 0
`define RM_DIV_LO_BIT 4
`define RM_DIV_HI_BIT 5
`define CS_CLK_MSB 2
`define CS_CLK_LSB 0
`define NIB_LO_MSB 3
`define NIB_LO_LSB 0
`define NIB_HI_MSB 7
`define NIB_HI_LSB 4

// ----------
// slice count field codes and last slice indices
// ----------
`define SLICE_CODE_EIGHT 3'h0
`define SLICE_CODE_FOUR 3'h1
`define SLICE_CODE_THREE 3'h2
`define SLICE_CODE_TWO 3'h3
`define SLICE_CODE_STATIC 3'h4
`define SLICES_EIGHT 3'h7
`define SLICES_FOUR 3'h3
`define SLICES_THREE 3'h2
`define SLICES_TWO 3'h1
`define SLICES_STATIC 3'h0

// ----------
// half-slice divider: period is 2 to the (16 - base + select) clocks
// ----------
`define DIV_ALL_ONES 16'hffff
`define DIV_SHIFT_BASE 4'hc
`define DIV_SEL_MAX 3'h5
`define SLICE_ZERO 3'h0

`endif

// >>> lcd_scan_pkg.sv
// shared types of the lcd key scan control
package lcd_scan_pkg;

    // pin drive condition applied to every segment and common pin
    typedef enum logic [1:0] {
        DRIVE_GROUND = 2'h0,
        DRIVE_DESELECT = 2'h1,
        DRIVE_DISPLAY = 2'h3
    } drive_e;

    // frame sequencer, gray coded along off, display, first half, latter half
    typedef enum logic [1:0] {
        SEQ_OFF = 2'h0,
        SEQ_DISPLAY = 2'h1,
        SEQ_SCAN_FIRST = 2'h3,
        SEQ_SCAN_LATTER = 2'h2
    } seq_state_e;

endpackage

// >>> lcd_key_scan_ctrl.sv
// lcd controller setup registers, frame sequencer and segment key scan control
`timescale 1ns/1ns
`include "lcd_scan_defs.svh"

// Notes on behaviour
// - scan input pin: pull-up only during scan
// - other pins: option bit sets pull-up directly
// - low group bits 0-3: strobes 0-3 first half
// - low group bits 4-7: strobes 0-3 latter half
// - high group bits 0-3: strobes 4-7 first half
// - high group bits 4-7: strobes 4-7 latter half
// - drive enable set: deselect levels, no display
// - display on: drive from display memory
// - display off: deselect levels on all pins
// - drive enable clear: ground on all pins
// - divider field bits 4,5; zero disconnects resistors
// - resistor mode bit 0 enables key scan
// - display mode bits 0-2 pick slice count
// - display mode bit 4 enables gate boost
// - key return change may raise interrupt flag
// - one scan slice after each lcd cycle
// - segments 24-31 follow level nibbles per half
module lcd_key_scan_ctrl (
    input wire logic mclk_in,                        // 50 MHz clock
    input wire logic nrst_in,                        // async reset, active low
    input wire logic [15:0] addr_in,                 // register address
    input wire logic wr_in,                          // write strobe
    input wire logic rd_in,                          // read strobe
    input wire logic [7:0] wdata_in,                 // write data
    output logic [7:0] rdata_out,                    // read data, one cycle after rd_in
    output lcd_scan_pkg::drive_e pin_drive_out,      // drive condition of seg/com pins
    output logic [2:0] com_slice_out,                // active common slice
    output logic com_blank_out,                      // commons show no display
    output logic key_scan_period_out,                // key scan output period
    output logic key_scan_latter_out,                // latter half of scan period
    output logic [7:0] key_strobe_level_out,         // levels of segments 24 to 31
    output logic [7:0] pull_up_enable_out,           // port 4 pull-up connect
    output logic [7:0] port4_input_mode_out,         // port 4 direction, 1 is input
    output logic [7:0] key_return_select_out,        // key scan input pin select
    output logic key_return_changed_out,             // pulse: key return select changed
    output logic gate_boost_out,                     // internal gate boost on
    output logic [1:0] divider_select_out,           // resistor division field
    output logic internal_divider_out,               // internal division chosen
    output logic resistors_connected_out             // internal resistors connected
);

    // ----------
    // reset release
    // ----------
    logic rst_meta_r;
    logic rst_sync_r;

    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end

    // the rest of the block leaves reset two edges after the pin
    wire rst_n = rst_sync_r;

    // ----------
    // register file
    // ----------
    logic [7:0] level_low_r;
    logic [7:0] level_high_r;
    logic [7:0] pull_up_r;
    logic [7:0] port4_dir_r;
    logic [7:0] key_return_r;
    logic [7:0] clock_sel_r;
    logic [7:0] display_mode_r;
    logic [7:0] resistor_mode_r;

    logic key_return_changed_r;

    wire sel_level_low = (addr_in == `ADDR_LEVEL_LOW);
    wire sel_level_high = (addr_in == `ADDR_LEVEL_HIGH);
    wire sel_pull_up = (addr_in == `ADDR_PULL_UP);
    wire sel_port4_dir = (addr_in == `ADDR_PORT4_DIR);
    wire sel_key_return = (addr_in == `ADDR_KEY_RETURN);
    wire sel_clock_sel = (addr_in == `ADDR_CLOCK_SEL);
    wire sel_display_mode = (addr_in == `ADDR_DISPLAY_MODE);
    wire sel_resistor_mode = (addr_in == `ADDR_RESISTOR_MODE);

    wire wr_key_return = wr_in && sel_key_return;
    // any change of the key scan input selection can disturb the key return lines
    wire key_return_differs = (wdata_in != key_return_r);

    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            level_low_r <= `RST_ZERO;
            level_high_r <= `RST_ZERO;
            pull_up_r <= `RST_ZERO;
            port4_dir_r <= `RST_PORT4_DIR;
            key_return_r <= `RST_ZERO;
            clock_sel_r <= `RST_ZERO;
            display_mode_r <= `RST_ZERO;
            resistor_mode_r <= `RST_ZERO;
        end else if (wr_in) begin
            if (sel_level_low) begin
                level_low_r <= wdata_in;
            end
            if (sel_level_high) begin
                level_high_r <= wdata_in;
            end
            if (sel_pull_up) begin
                pull_up_r <= wdata_in;
            end
            if (sel_port4_dir) begin
                port4_dir_r <= wdata_in;
            end
            if (sel_key_return) begin
                key_return_r <= wdata_in;
            end
            if (sel_clock_sel) begin
                clock_sel_r <= wdata_in & `MASK_CLOCK_SEL;
            end
            if (sel_display_mode) begin
                display_mode_r <= wdata_in & `MASK_DISPLAY_MODE;
            end
            if (sel_resistor_mode) begin
                resistor_mode_r <= wdata_in & `MASK_RESISTOR_MODE;
            end
        end
    end

    // rewriting the same value raises no pulse
    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            key_return_changed_r <= 1'b0;
        end else begin
            key_return_changed_r <= wr_key_return && key_return_differs;
        end
    end

    // read data, unmapped addresses read as zero
    wire [7:0] read_mux =
        ({8{sel_level_low}} & level_low_r) |
        ({8{sel_level_high}} & level_high_r) |
        ({8{sel_pull_up}} & pull_up_r) |
        ({8{sel_port4_dir}} & port4_dir_r) |
        ({8{sel_key_return}} & key_return_r) |
        ({8{sel_clock_sel}} & clock_sel_r) |
        ({8{sel_display_mode}} & display_mode_r) |
        ({8{sel_resistor_mode}} & resistor_mode_r);

    // read data holds until the next read strobe
    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            rdata_out <= `RST_ZERO;
        end else if (rd_in) begin
            rdata_out <= read_mux;
        end
    end

    // ----------
    // control field decode
    // ----------
    wire [2:0] slice_code = display_mode_r[`DM_SLICE_MSB:`DM_SLICE_LSB];
    wire drive_enable = display_mode_r[`DM_DRIVE_BIT];
    wire display_on = display_mode_r[`DM_ON_BIT];
    wire key_scan_enable = resistor_mode_r[`RM_KEY_SCAN_BIT];

    wire [1:0] divider_field = {resistor_mode_r[`RM_DIV_HI_BIT],
                                resistor_mode_r[`RM_DIV_LO_BIT]};

    assign gate_boost_out = display_mode_r[`DM_BOOST_BIT];
    assign divider_select_out = divider_field;
    assign internal_divider_out = divider_field[0];
    assign resistors_connected_out = (divider_field != 2'h0);
    assign port4_input_mode_out = port4_dir_r;
    assign key_return_select_out = key_return_r;
    assign key_return_changed_out = key_return_changed_r;

    // last slice index of one lcd output cycle
    logic [2:0] last_slice;
    always_comb begin
        case (slice_code)
            `SLICE_CODE_EIGHT: last_slice = `SLICES_EIGHT;
            `SLICE_CODE_FOUR: last_slice = `SLICES_FOUR;
            `SLICE_CODE_THREE: last_slice = `SLICES_THREE;
            `SLICE_CODE_TWO: last_slice = `SLICES_TWO;
            `SLICE_CODE_STATIC: last_slice = `SLICES_STATIC;
            default: last_slice = `SLICES_STATIC;
        endcase
    end

    // ----------
    // lcd clock divider: one pulse per half time slice
    // ----------
    // prohibited select codes run at the slowest supported rate
    logic [15:0] div_cnt_r;

    wire [2:0] clk_sel_raw = clock_sel_r[`CS_CLK_MSB:`CS_CLK_LSB];
    wire [2:0] clk_sel = (clk_sel_raw > `DIV_SEL_MAX) ? `DIV_SEL_MAX : clk_sel_raw;
    wire [3:0] div_shift = `DIV_SHIFT_BASE - {1'b0, clk_sel};
    wire [15:0] div_mask = `DIV_ALL_ONES >> div_shift;
    wire half_tick = ((div_cnt_r & div_mask) == div_mask);

    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt_r <= 16'h0000;
        end else begin
            div_cnt_r <= div_cnt_r + 16'h0001;
        end
    end

    // ----------
    // frame sequencer
    // ----------
    lcd_scan_pkg::seq_state_e state_r;
    lcd_scan_pkg::seq_state_e state_nxt;
    logic [2:0] slice_r;
    logic [2:0] slice_nxt;
    logic half_r;
    logic half_nxt;

    // frames run only while drive and display are both on
    wire running = drive_enable && display_on;
    wire slice_end = half_tick && half_r;
    wire cycle_end = slice_end && (slice_r >= last_slice);

    always_comb begin
        state_nxt = state_r;
        slice_nxt = slice_r;
        half_nxt = half_r ^ half_tick;

        case (state_r)
            lcd_scan_pkg::SEQ_OFF: begin
                half_nxt = 1'b0;
                slice_nxt = `SLICE_ZERO;
                if (running) begin
                    state_nxt = lcd_scan_pkg::SEQ_DISPLAY;
                end
            end
            lcd_scan_pkg::SEQ_DISPLAY: begin
                if (cycle_end) begin
                    slice_nxt = `SLICE_ZERO;
                    if (key_scan_enable) begin
                        state_nxt = lcd_scan_pkg::SEQ_SCAN_FIRST;
                    end
                end else if (slice_end) begin
                    slice_nxt = slice_r + 3'h1;
                end
            end
            lcd_scan_pkg::SEQ_SCAN_FIRST: begin
                if (half_tick) begin
                    state_nxt = lcd_scan_pkg::SEQ_SCAN_LATTER;
                end
            end
            lcd_scan_pkg::SEQ_SCAN_LATTER: begin
                if (half_tick) begin
                    state_nxt = lcd_scan_pkg::SEQ_DISPLAY;
                end
            end
            default: begin
                state_nxt = lcd_scan_pkg::SEQ_OFF;
            end
        endcase

        // stopping wins over any step of the frame
        if (!running) begin
            state_nxt = lcd_scan_pkg::SEQ_OFF;
            slice_nxt = `SLICE_ZERO;
            half_nxt = 1'b0;
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= lcd_scan_pkg::SEQ_OFF;
            slice_r <= `SLICE_ZERO;
            half_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            slice_r <= slice_nxt;
            half_r <= half_nxt;
        end
    end

    // ----------
    // key scan strobe and pin drive
    // ----------
    // the pull-ups decode state_r and the level nibbles are registered from state_nxt, so both change on the same edge
    wire scan_first = (state_r == lcd_scan_pkg::SEQ_SCAN_FIRST);
    wire scan_latter = (state_r == lcd_scan_pkg::SEQ_SCAN_LATTER);
    wire scan_period = scan_first || scan_latter;

    assign key_scan_period_out = scan_period;
    assign key_scan_latter_out = scan_latter;
    assign com_slice_out = slice_r;
    assign com_blank_out = scan_period || (state_r == lcd_scan_pkg::SEQ_OFF);

    // drive enable clear wins over display on
    assign pin_drive_out = !drive_enable ? lcd_scan_pkg::DRIVE_GROUND :
                           !display_on ? lcd_scan_pkg::DRIVE_DESELECT :
                           lcd_scan_pkg::DRIVE_DISPLAY;

    wire [3:0] low_first = level_low_r[`NIB_LO_MSB:`NIB_LO_LSB];
    wire [3:0] low_latter = level_low_r[`NIB_HI_MSB:`NIB_HI_LSB];
    wire [3:0] high_first = level_high_r[`NIB_LO_MSB:`NIB_LO_LSB];
    wire [3:0] high_latter = level_high_r[`NIB_HI_MSB:`NIB_HI_LSB];

    wire scan_first_nxt = (state_nxt == lcd_scan_pkg::SEQ_SCAN_FIRST);
    wire scan_latter_nxt = (state_nxt == lcd_scan_pkg::SEQ_SCAN_LATTER);

    wire [7:0] strobe_level_nxt =
        scan_first_nxt ? {high_first, low_first} :
        scan_latter_nxt ? {high_latter, low_latter} :
        8'h00;

    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            key_strobe_level_out <= `RST_ZERO;
        end else begin
            key_strobe_level_out <= strobe_level_nxt;
        end
    end

    // ----------
    // port 4 pull-up control
    // ----------
    // a scan input pin with its option bit set is a prohibited setting; it is kept off
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_pull_up
            wire scan_input = key_scan_enable && key_return_r[gi] && port4_dir_r[gi];
            assign pull_up_enable_out[gi] = scan_input ?
                (!pull_up_r[gi] && scan_period) :
                pull_up_r[gi];
        end
    endgenerate

endmodule

// >>> lcd_key_scan_ctrl_checker.sv
// port assertions for the lcd key scan control
`timescale 1ns/1ns
`include "lcd_scan_defs.svh"
module lcd_key_scan_ctrl_checker (
    input wire logic mclk_in,                    // clock
    input wire logic nrst_in,                    // reset, active low
    input wire logic [15:0] addr_in,             // register address
    input wire logic wr_in,                      // write strobe
    input wire logic [7:0] wdata_in,             // write data
    input wire lcd_scan_pkg::drive_e pin_drive_out, // pin drive condition
    input wire logic [2:0] com_slice_out,        // active slice
    input wire logic com_blank_out,              // commons blank
    input wire logic key_scan_period_out,        // scan period
    input wire logic key_scan_latter_out,        // scan latter half
    input wire logic [7:0] key_strobe_level_out, // strobe levels
    input wire logic [7:0] key_return_select_out, // key return select
    input wire logic key_return_changed_out,     // change pulse
    input wire logic gate_boost_out,             // gate boost
    input wire logic [1:0] divider_select_out,   // divider field
    input wire logic internal_divider_out,       // internal division
    input wire logic resistors_connected_out     // resistors connected
);
    wire dm_wr = wr_in && addr_in == `ADDR_DISPLAY_MODE;
    wire rm_wr = wr_in && addr_in == `ADDR_RESISTOR_MODE;
    logic [7:0] lo_s;
    logic [7:0] hi_s;
    logic [7:0] wd_q;
    // shadows of the level registers; writes during a scan half are not modelled
    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            lo_s <= 8'h00;
            hi_s <= 8'h00;
        end else if (wr_in && addr_in == `ADDR_LEVEL_LOW) begin
            lo_s <= wdata_in;
        end else if (wr_in && addr_in == `ADDR_LEVEL_HIGH) begin
            hi_s <= wdata_in;
        end
    end
    always_ff @(posedge mclk_in) begin
        wd_q <= wdata_in;
    end
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!nrst_in);
    a_drive_ground: assert property (dm_wr && !wdata_in[6] |=> pin_drive_out == 2'h0)
        else $error("pins not grounded");
    a_drive_deselect: assert property (dm_wr && wdata_in[7:6] == 2'h1 |=> pin_drive_out == 2'h1)
        else $error("pins not deselected");
    a_drive_display: assert property (dm_wr && wdata_in[7:6] == 2'h3 |=> pin_drive_out == 2'h3)
        else $error("pins not displaying");
    a_boost_follow: assert property (dm_wr |=> gate_boost_out == wd_q[4])
        else $error("gate boost wrong");
    a_divider_follow: assert property (rm_wr |=> divider_select_out == wd_q[5:4] &&
        internal_divider_out == wd_q[4] && resistors_connected_out == (wd_q[5:4] != 2'h0))
        else $error("divider outputs wrong");
    a_first_level: assert property ($rose(key_scan_period_out) |->
        key_strobe_level_out == {hi_s[3:0], lo_s[3:0]})
        else $error("first half levels wrong");
    a_latter_level: assert property ($rose(key_scan_latter_out) |->
        key_scan_period_out && key_strobe_level_out == {hi_s[7:4], lo_s[7:4]})
        else $error("latter half levels wrong");
    a_level_idle: assert property (!key_scan_period_out |-> key_strobe_level_out == 8'h00)
        else $error("levels outside scan");
    a_scan_blank: assert property (key_scan_period_out |-> com_blank_out)
        else $error("commons not blank during scan");
    a_scan_end: assert property ($fell(key_scan_latter_out) && pin_drive_out == 2'h3 |->
        com_slice_out == 3'h0 && !com_blank_out && !key_scan_period_out)
        else $error("scan not followed by slice zero");
    a_latter_bound: assert property ($rose(key_scan_latter_out) |-> ##[1:600] !key_scan_latter_out)
        else $error("latter half too long");
    a_off_blank: assert property (dm_wr && wdata_in[7:6] != 2'h3 |=> ##1
        com_blank_out && !key_scan_period_out)
        else $error("display stays active after off");
    a_return_pulse: assert property (wr_in && addr_in == `ADDR_KEY_RETURN &&
        wdata_in != key_return_select_out |-> ##[1:2] key_return_changed_out)
        else $error("no key return change pulse");
    c_scan: cover property ($rose(key_scan_period_out));
    c_latter: cover property ($rose(key_scan_latter_out));
    c_display: cover property (pin_drive_out == 2'h3);
    c_pulse: cover property (key_return_changed_out);
endmodule

bind lcd_key_scan_ctrl lcd_key_scan_ctrl_checker chk_i (.mclk_in, .nrst_in, .addr_in, .wr_in,
    .wdata_in, .pin_drive_out, .com_slice_out, .com_blank_out, .key_scan_period_out,
    .key_scan_latter_out, .key_strobe_level_out, .key_return_select_out,
    .key_return_changed_out, .gate_boost_out, .divider_select_out, .internal_divider_out,
    .resistors_connected_out);

// >>> lcd_panel_model.sv
// key matrix side: latches the strobe levels seen in each scan half
`timescale 1ns/1ns
module lcd_panel_model (
    input wire logic clk_in,          // clock
    input wire logic nrst_in,         // reset, active low
    input wire logic scan_in,         // scan period
    input wire logic latter_in,       // latter half
    input wire logic [7:0] level_in,  // strobe levels
    output logic [7:0] first_out,     // levels of first half
    output logic [7:0] latter_out,    // levels of latter half
    output logic [7:0] scans_out      // scan periods seen
);
    logic scan_q;
    logic latter_q;
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            scan_q <= 1'b0;
            latter_q <= 1'b0;
            first_out <= 8'h00;
            latter_out <= 8'h00;
            scans_out <= 8'h00;
        end else begin
            scan_q <= scan_in;
            latter_q <= latter_in;
            if (scan_in && !scan_q) begin
                first_out <= level_in;
                scans_out <= scans_out + 8'h01;
            end
            if (latter_in && !latter_q) begin
                latter_out <= level_in;
            end
        end
    end
endmodule

// >>> lcd_key_scan_ctrl_tb_top.sv
// self-checking bench of the lcd key scan control
`timescale 1ns/1ns
`include "lcd_scan_defs.svh"
module lcd_key_scan_ctrl_tb_top;
    logic mclk_in, nrst_in, wr_in, rd_in, com_blank_out, key_scan_period_out;
    logic key_scan_latter_out, key_return_changed_out, gate_boost_out;
    logic internal_divider_out, resistors_connected_out;
    logic [15:0] addr_in;
    logic [7:0] wdata_in, rdata_out, key_strobe_level_out, pull_up_enable_out;
    logic [7:0] port4_input_mode_out, key_return_select_out, first_cap, latter_cap, scans;
    logic [2:0] com_slice_out, sel;
    logic [1:0] divider_select_out;
    lcd_scan_pkg::drive_e pin_drive_out;
    logic [7:0] v, lo, hi, pu, kr, dr;
    int errors, num_checks, n, h;
    logic [15:0] a_tab [9] = '{`ADDR_LEVEL_LOW, `ADDR_LEVEL_HIGH, `ADDR_PULL_UP,
        `ADDR_PORT4_DIR, `ADDR_KEY_RETURN, `ADDR_CLOCK_SEL, `ADDR_DISPLAY_MODE,
        `ADDR_RESISTOR_MODE, 16'hff00};
    logic [7:0] m_tab [9] = '{`MASK_ALL, `MASK_ALL, `MASK_ALL, `MASK_ALL, `MASK_ALL,
        `MASK_CLOCK_SEL, `MASK_DISPLAY_MODE, `MASK_RESISTOR_MODE, 8'h00};
    logic [1:0] d_tab [4] = '{2'h0, 2'h1, 2'h0, 2'h3};

    lcd_key_scan_ctrl dut (.mclk_in, .nrst_in, .addr_in, .wr_in, .rd_in, .wdata_in,
        .rdata_out, .pin_drive_out, .com_slice_out, .com_blank_out, .key_scan_period_out,
        .key_scan_latter_out, .key_strobe_level_out, .pull_up_enable_out,
        .port4_input_mode_out, .key_return_select_out, .key_return_changed_out,
        .gate_boost_out, .divider_select_out, .internal_divider_out, .resistors_connected_out);
    lcd_panel_model panel (.clk_in(mclk_in), .nrst_in(nrst_in), .scan_in(key_scan_period_out),
        .latter_in(key_scan_latter_out), .level_in(key_strobe_level_out),
        .first_out(first_cap), .latter_out(latter_cap), .scans_out(scans));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
        @(posedge mclk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge mclk_in);
        wr_in <= 1'b0;
    endtask
    task automatic rd_reg(input logic [15:0] a, output logic [7:0] d);
        @(posedge mclk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge mclk_in);
        rd_in <= 1'b0;
        @(posedge mclk_in);
        #1 d = rdata_out;
    endtask
    // bounded wait for a sequencer state, returns the cycles spent
    task automatic wait_st(input logic p, input logic l, output int c);
        c = 0;
        while (!(key_scan_period_out === p && key_scan_latter_out === l) && c < 5000) begin
            @(posedge mclk_in);
            #1 c++;
        end
        if (c >= 5000) chk(16'h0, 16'h1);
    endtask
    function automatic int slices(input logic [2:0] code);
        case (code)
            `SLICE_CODE_EIGHT: return 8;
            `SLICE_CODE_FOUR: return 4;
            `SLICE_CODE_THREE: return 3;
            `SLICE_CODE_TWO: return 2;
            default: return 1;
        endcase
    endfunction
    function automatic logic [7:0] exp_pull(input logic ks, input logic scan);
        logic [7:0] m;
        m = {8{ks}} & kr & dr;
        return (m & ~pu & {8{scan}}) | (~m & pu);
    endfunction
    task automatic conclude();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        mclk_in = 1'b0;
        forever #10 mclk_in = ~mclk_in;
    end
    initial begin
        #2000000;
        errors++;
        conclude();
    end
    initial begin
        errors = 0;
        num_checks = 0;
        nrst_in = 1'b0;
        addr_in = 16'h0000;
        wr_in = 1'b0;
        rd_in = 1'b0;
        wdata_in = 8'h00;
        void'($urandom(83018));
        repeat (6) @(posedge mclk_in);
        nrst_in <= 1'b1;
        repeat (3) @(posedge mclk_in);
        for (int i = 0; i < 9; i++) begin
            rd_reg(a_tab[i], v);
            chk(v, i == 3 ? `RST_PORT4_DIR : `RST_ZERO);
            v = 8'($urandom());
            wr_reg(a_tab[i], v);
            rd_reg(a_tab[i], lo);
            chk(lo, v & m_tab[i]);
        end
        for (int i = 0; i < 4; i++) begin
            wr_reg(`ADDR_DISPLAY_MODE, {i[1:0], 6'h10});
            @(posedge mclk_in);
            #1 chk(pin_drive_out, d_tab[i]);
            chk(gate_boost_out, 1'b1);
        end
        for (int i = 0; i < 4; i++) begin
            wr_reg(`ADDR_RESISTOR_MODE, {2'h0, i[1:0], 4'h0});
            @(posedge mclk_in);
            #1 chk({divider_select_out, internal_divider_out, resistors_connected_out},
                {i[1:0], i[0], i[1:0] != 2'h0});
        end
        for (int code = 0; code < 6; code++) begin
            lo = 8'($urandom());
            hi = 8'($urandom());
            kr = 8'($urandom());
            dr = 8'($urandom()) | kr;
            pu = 8'($urandom()) & ~kr;
            sel = code == 4 ? `DIV_SEL_MAX : 3'($urandom_range(0, 2));
            h = 16 << sel;
            // enable order with key scan, display stopped first
            wr_reg(`ADDR_DISPLAY_MODE, 8'h10);
            wr_reg(`ADDR_RESISTOR_MODE, 8'h11);
            wr_reg(`ADDR_PORT4_DIR, dr);
            wr_reg(`ADDR_PULL_UP, pu);
            wr_reg(`ADDR_KEY_RETURN, kr);
            wr_reg(`ADDR_LEVEL_LOW, lo);
            wr_reg(`ADDR_LEVEL_HIGH, hi);
            wr_reg(`ADDR_DISPLAY_MODE, {5'h02, code[2:0]});
            wr_reg(`ADDR_CLOCK_SEL, {5'h00, sel});
            wr_reg(`ADDR_DISPLAY_MODE, {5'h0a, code[2:0]});
            wr_reg(`ADDR_DISPLAY_MODE, {5'h1a, code[2:0]});
            @(posedge mclk_in);
            #1 chk(pull_up_enable_out, exp_pull(1'b1, 1'b0));
            chk({port4_input_mode_out, key_return_select_out}, {dr, kr});
            // first frame may start mid-slice, so measure the second one
            wait_st(1'b1, 1'b0, n);
            wait_st(1'b0, 1'b0, n);
            wait_st(1'b1, 1'b0, n);
            chk(n, slices(code[2:0]) * 2 * h);
            chk(pull_up_enable_out, exp_pull(1'b1, 1'b1));
            chk(com_blank_out, 1'b1);
            wait_st(1'b1, 1'b1, n);
            chk(n, h);
            chk(first_cap, {hi[3:0], lo[3:0]});
            wait_st(1'b0, 1'b0, n);
            chk(n, h);
            chk(latter_cap, {hi[7:4], lo[7:4]});
            chk({com_slice_out, key_strobe_level_out}, 11'h000);
            chk(pull_up_enable_out, exp_pull(1'b1, 1'b0));
        end
        pu = 8'hff;
        wr_reg(`ADDR_RESISTOR_MODE, 8'h10);
        wr_reg(`ADDR_PULL_UP, pu);
        v = scans;
        repeat (1200) @(posedge mclk_in);
        #1 chk(scans, v);
        chk(pull_up_enable_out, 8'hff);
        wr_reg(`ADDR_RESISTOR_MODE, 8'h11);
        wait_st(1'b1, 1'b0, n);
        wr_reg(`ADDR_DISPLAY_MODE, 8'h54);
        repeat (2) @(posedge mclk_in);
        #1 chk({pin_drive_out, com_blank_out, key_scan_period_out, key_strobe_level_out},
            {2'h1, 2'h2, 8'h00});
        wr_reg(`ADDR_DISPLAY_MODE, 8'h00);
        wr_reg(`ADDR_RESISTOR_MODE, 8'h00);
        @(posedge mclk_in);
        #1 chk({pin_drive_out, resistors_connected_out, gate_boost_out}, 4'h0);
        conclude();
    end
endmodule
